/* File: gauge_cfg_pkg.sv */
// constants, register layout and types for the gauge configuration register bank
`default_nettype none

package gauge_cfg_pkg;

    // =====================================================================
    // register offsets on the two-wire bus
    localparam logic [7:0] NOMINAL_CAPACITY_ADDR = 8'h18;
    localparam logic [7:0] GENERAL_CONFIGURATION_ADDR = 8'h1D;
    localparam logic [7:0] CHARGE_END_CURRENT_ADDR = 8'h1E;
    localparam logic [7:0] EMPTY_THRESHOLDS_ADDR = 8'h3A;
    localparam logic [7:0] SECONDARY_CONFIGURATION_ADDR = 8'hBB;
    localparam logic [7:0] MODEL_OPTIONS_ADDR = 8'hDB;
    localparam logic [7:0] ALERT_FLAGS_ADDR = 8'hF0;

    // =====================================================================
    // reset values
    localparam logic [15:0] NOMINAL_CAPACITY_RST = 16'h0BB8;
    localparam logic [15:0] GENERAL_CONFIGURATION_RST = 16'h2210;
    localparam logic [15:0] CHARGE_END_CURRENT_RST = 16'h0640;
    localparam logic [15:0] EMPTY_THRESHOLDS_RST = 16'hA561;
    localparam logic [15:0] SECONDARY_CONFIGURATION_RST = 16'h3658;
    localparam logic [15:0] MODEL_OPTIONS_RST = 16'h0000;

    // =====================================================================
    // field positions and write masks
    localparam logic [15:0] MODEL_OPTIONS_WMASK = 16'hA4FC;
    localparam logic [15:0] GENERAL_CONFIGURATION_WMASK = 16'hFFDF;
    localparam int MO_RELOAD_BIT = 15;
    localparam int MO_MODEL_LSB = 4;
    localparam int MO_CELL_COUNT_BIT = 3;
    localparam int MO_SENSE_SIDE_BIT = 2;
    localparam int GC_STICKY_LSB = 11;
    localparam int GC_ALERT_EN_BIT = 2;
    localparam int ET_TARGET_LSB = 7;
    localparam int ALERT_CLASSES = 4;

    // accepted battery model selections
    localparam logic [3:0] MODEL_COBALT_OXIDE = 4'h0;
    localparam logic [3:0] MODEL_NICKEL_COBALT_AL = 4'h2;
    localparam logic [3:0] MODEL_IRON_PHOSPHATE = 4'h6;

    // standard word encodings, lsb sizes in nano or pico units or as divisors
    localparam int CAPACITY_LSB_NVH = 5000;
    localparam int PERCENT_LSB_DIV = 256;
    localparam int CURRENT_LSB_PV = 1562500;
    localparam int TEMPERATURE_LSB_DIV = 256;

    // =====================================================================
    // types
    typedef struct packed {
        logic [15:0] nominal_capacity;
        logic [15:0] general_configuration;
        logic [15:0] charge_end_current;
        logic [15:0] empty_thresholds;
        logic [15:0] secondary_configuration;
        logic [15:0] model_options;
    } reg_bank_t;

    typedef enum logic [3:0] {
        LINK_IDLE = 4'h0,
        LINK_DEV_ADDR = 4'h1,
        LINK_DEV_ACK = 4'h3,
        LINK_REG_ADDR = 4'h2,
        LINK_REG_ACK = 4'h6,
        LINK_WR_DATA = 4'h7,
        LINK_WR_ACK = 4'h5,
        LINK_RD_DATA = 4'h4,
        LINK_RD_ACK = 4'hC
    } link_state_t;

endpackage

`default_nettype wire

/* File: gauge_config_registers.sv */
// configuration register bank of the fuel gauge, reached over the two-wire serial bus
`default_nettype none

module gauge_config_registers #(
    parameter logic [6:0] DEVICE_ADDR = 7'h2A // arbitrary bus address
) (
    input wire logic sys_clk_in,
    input wire logic rst_in,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe_out,
    output logic alert_out,
    output logic alert_oe_out,
    input wire logic task_tick_in,
    input wire logic reload_done_in,
    input wire logic boot_high_side_in,
    input wire logic boot_multi_cell_in,
    input wire logic [3:0] threshold_exceeded_in,
    input wire logic [9:0] cell_voltage_in,
    output gauge_cfg_pkg::reg_bank_t config_out,
    output logic [3:0] alert_flags_out,
    output logic empty_out
);

    // =====================================================================
    // state
    typedef struct packed {
        logic [2:0] scl_s;
        logic [2:0] sda_s;
        logic scl_f;
        logic sda_f;
        logic scl_p;
        logic sda_p;
        gauge_cfg_pkg::link_state_t fsm;
        logic [3:0] bitcnt;
        logic [7:0] shift;
        logic [7:0] tx;
        logic rw;
        logic byte_idx;
        logic [7:0] ptr;
        logic [7:0] low;
        logic sda_oe;
        gauge_cfg_pkg::reg_bank_t regs;
        gauge_cfg_pkg::reg_bank_t shadow;
        logic [3:0] flags;
        logic alert_oe;
        logic empty;
        logic boot_done;
    } state_t;

    state_t state_q, state_d;
    // bus events from the filtered lines
    logic scl_rise, scl_fall, bus_start, bus_stop, commit;
    logic [15:0] wr_word;
    logic [3:0] clr_vec, sticky_vec;
    assign scl_rise = state_q.scl_f & ~state_q.scl_p;
    assign scl_fall = ~state_q.scl_f & state_q.scl_p;
    assign bus_start = state_q.scl_f & state_q.scl_p & ~state_q.sda_f & state_q.sda_p;
    assign bus_stop = state_q.scl_f & state_q.scl_p & state_q.sda_f & ~state_q.sda_p;
    // a word is stored only once its high byte arrives
    assign commit = scl_fall && state_q.fsm == gauge_cfg_pkg::LINK_WR_DATA
                    && state_q.bitcnt == 4'h8 && state_q.byte_idx;
    assign wr_word = {state_q.shift, state_q.low};
    assign sticky_vec = state_q.regs.general_configuration[gauge_cfg_pkg::GC_STICKY_LSB +: 4];
    // writing zero to a flag clears it, writing one leaves it
    assign clr_vec = (commit && state_q.ptr == gauge_cfg_pkg::ALERT_FLAGS_ADDR) ? ~wr_word[3:0] : 4'h0;

    // =====================================================================
    // read multiplexer, low byte goes out first
    function automatic logic [7:0] read_byte(input gauge_cfg_pkg::reg_bank_t r, input logic [3:0] f,
                                             input logic [7:0] a, input logic hi);
        logic [15:0] w;
        w = 16'h0000;
        case (a)
            gauge_cfg_pkg::NOMINAL_CAPACITY_ADDR: w = r.nominal_capacity;
            gauge_cfg_pkg::GENERAL_CONFIGURATION_ADDR: w = r.general_configuration;
            gauge_cfg_pkg::CHARGE_END_CURRENT_ADDR: w = r.charge_end_current;
            gauge_cfg_pkg::EMPTY_THRESHOLDS_ADDR: w = r.empty_thresholds;
            gauge_cfg_pkg::SECONDARY_CONFIGURATION_ADDR: w = r.secondary_configuration;
            gauge_cfg_pkg::MODEL_OPTIONS_ADDR: w = r.model_options;
            gauge_cfg_pkg::ALERT_FLAGS_ADDR: w = {12'h000, f};
            default: w = 16'h0000; // unmapped reads as zero
        endcase
        return hi ? w[15:8] : w[7:0];
    endfunction

    // =====================================================================
    // next-state logic
    always_comb begin
        logic [3:0] model_sel;
        logic [15:0] mo_word;
        model_sel = 4'h0;
        mo_word = 16'h0000;
        state_d = state_q;
        // three-stage sampling; a level counts once stages two and three agree
        state_d.scl_s = {state_q.scl_s[1:0], scl_in};
        state_d.sda_s = {state_q.sda_s[1:0], sda_in};
        if (state_q.scl_s[2] == state_q.scl_s[1]) begin
            state_d.scl_f = state_q.scl_s[2];
        end
        if (state_q.sda_s[2] == state_q.sda_s[1]) begin
            state_d.sda_f = state_q.sda_s[2];
        end
        state_d.scl_p = state_q.scl_f;
        state_d.sda_p = state_q.sda_f;
        // serial slave; start and stop override any bit activity
        if (bus_start) begin
            state_d.fsm = gauge_cfg_pkg::LINK_DEV_ADDR;
            state_d.bitcnt = 4'h0;
            state_d.byte_idx = 1'b0;
            state_d.sda_oe = 1'b0;
        end else if (bus_stop) begin
            state_d.fsm = gauge_cfg_pkg::LINK_IDLE;
            state_d.sda_oe = 1'b0;
        end else if (scl_rise) begin
            case (state_q.fsm)
                gauge_cfg_pkg::LINK_DEV_ADDR,
                gauge_cfg_pkg::LINK_REG_ADDR,
                gauge_cfg_pkg::LINK_WR_DATA: begin
                    state_d.shift = {state_q.shift[6:0], state_q.sda_f};
                    state_d.bitcnt = state_q.bitcnt + 4'h1;
                end
                gauge_cfg_pkg::LINK_RD_DATA: begin
                    state_d.bitcnt = state_q.bitcnt + 4'h1;
                end
                gauge_cfg_pkg::LINK_RD_ACK: begin
                    state_d.rw = ~state_q.sda_f; // master ack keeps the read going
                end
                default: ;
            endcase
        end else if (scl_fall) begin
            case (state_q.fsm)
                gauge_cfg_pkg::LINK_DEV_ADDR: begin
                    if (state_q.bitcnt == 4'h8) begin
                        if (state_q.shift[7:1] == DEVICE_ADDR) begin
                            state_d.fsm = gauge_cfg_pkg::LINK_DEV_ACK;
                            state_d.rw = state_q.shift[0];
                            state_d.sda_oe = 1'b1;
                        end else begin
                            state_d.fsm = gauge_cfg_pkg::LINK_IDLE;
                        end
                    end
                end
                gauge_cfg_pkg::LINK_DEV_ACK: begin
                    state_d.bitcnt = 4'h0;
                    if (state_q.rw) begin
                        state_d.fsm = gauge_cfg_pkg::LINK_RD_DATA;
                        state_d.tx = read_byte(state_q.regs, state_q.flags, state_q.ptr, 1'b0);
                        state_d.sda_oe = ~state_d.tx[7];
                    end else begin
                        state_d.fsm = gauge_cfg_pkg::LINK_REG_ADDR;
                        state_d.sda_oe = 1'b0;
                    end
                end
                gauge_cfg_pkg::LINK_REG_ADDR: begin
                    if (state_q.bitcnt == 4'h8) begin
                        state_d.ptr = state_q.shift;
                        state_d.fsm = gauge_cfg_pkg::LINK_REG_ACK;
                        state_d.sda_oe = 1'b1;
                    end
                end
                gauge_cfg_pkg::LINK_REG_ACK,
                gauge_cfg_pkg::LINK_WR_ACK: begin
                    state_d.fsm = gauge_cfg_pkg::LINK_WR_DATA;
                    state_d.bitcnt = 4'h0;
                    state_d.sda_oe = 1'b0;
                end
                gauge_cfg_pkg::LINK_WR_DATA: begin
                    if (state_q.bitcnt == 4'h8) begin
                        state_d.low = state_q.shift;
                        state_d.byte_idx = ~state_q.byte_idx;
                        if (state_q.byte_idx) begin
                            state_d.ptr = state_q.ptr + 8'h01;
                        end
                        state_d.fsm = gauge_cfg_pkg::LINK_WR_ACK;
                        state_d.sda_oe = 1'b1;
                    end
                end
                gauge_cfg_pkg::LINK_RD_DATA: begin
                    if (state_q.bitcnt == 4'h8) begin
                        state_d.fsm = gauge_cfg_pkg::LINK_RD_ACK;
                        state_d.sda_oe = 1'b0;
                    end else begin
                        state_d.tx = {state_q.tx[6:0], 1'b0};
                        state_d.sda_oe = ~state_d.tx[7];
                    end
                end
                gauge_cfg_pkg::LINK_RD_ACK: begin
                    if (state_q.rw) begin
                        state_d.byte_idx = ~state_q.byte_idx;
                        if (state_q.byte_idx) begin
                            state_d.ptr = state_q.ptr + 8'h01;
                        end
                        state_d.tx = read_byte(state_q.regs, state_q.flags, state_d.ptr, state_d.byte_idx);
                        state_d.sda_oe = ~state_d.tx[7];
                        state_d.bitcnt = 4'h0;
                        state_d.fsm = gauge_cfg_pkg::LINK_RD_DATA;
                    end else begin
                        state_d.fsm = gauge_cfg_pkg::LINK_IDLE;
                    end
                end
                default: begin
                    state_d.fsm = gauge_cfg_pkg::LINK_IDLE;
                end
            endcase
        end
        // sense side and cell count are caught once, just after reset release
        if (!state_q.boot_done) begin
            state_d.boot_done = 1'b1;
            state_d.regs.model_options[gauge_cfg_pkg::MO_SENSE_SIDE_BIT] = boot_high_side_in;
            state_d.regs.model_options[gauge_cfg_pkg::MO_CELL_COUNT_BIT] = boot_multi_cell_in;
        end
        // reload finished: the engine drops the request bit itself
        if (reload_done_in) begin
            state_d.regs.model_options[gauge_cfg_pkg::MO_RELOAD_BIT] = 1'b0;
        end
        // whole-word register writes; reserved positions are not stored
        if (commit) begin
            case (state_q.ptr)
                gauge_cfg_pkg::NOMINAL_CAPACITY_ADDR: state_d.regs.nominal_capacity = wr_word;
                gauge_cfg_pkg::GENERAL_CONFIGURATION_ADDR: begin
                    state_d.regs.general_configuration = wr_word & gauge_cfg_pkg::GENERAL_CONFIGURATION_WMASK;
                end
                gauge_cfg_pkg::CHARGE_END_CURRENT_ADDR: state_d.regs.charge_end_current = wr_word;
                gauge_cfg_pkg::EMPTY_THRESHOLDS_ADDR: state_d.regs.empty_thresholds = wr_word;
                gauge_cfg_pkg::SECONDARY_CONFIGURATION_ADDR: state_d.regs.secondary_configuration = wr_word;
                gauge_cfg_pkg::MODEL_OPTIONS_ADDR: begin
                    mo_word = wr_word & gauge_cfg_pkg::MODEL_OPTIONS_WMASK;
                    model_sel = mo_word[gauge_cfg_pkg::MO_MODEL_LSB +: 4];
                    // an unsupported chemistry keeps the previous selection
                    if (model_sel != gauge_cfg_pkg::MODEL_COBALT_OXIDE
                        && model_sel != gauge_cfg_pkg::MODEL_NICKEL_COBALT_AL
                        && model_sel != gauge_cfg_pkg::MODEL_IRON_PHOSPHATE) begin
                        mo_word[gauge_cfg_pkg::MO_MODEL_LSB +: 4] =
                            state_q.regs.model_options[gauge_cfg_pkg::MO_MODEL_LSB +: 4];
                    end
                    state_d.regs.model_options = mo_word;
                end
                default: ;
            endcase
        end
        // alert flags: sticky classes latch, others follow the threshold; set wins
        for (int i = 0; i < gauge_cfg_pkg::ALERT_CLASSES; i++) begin
            if (sticky_vec[i]) begin
                state_d.flags[i] = (state_q.flags[i] & ~clr_vec[i]) | threshold_exceeded_in[i];
            end else begin
                state_d.flags[i] = threshold_exceeded_in[i];
            end
        end
        // enable gates the pin only, the flags keep running
        state_d.alert_oe = state_q.regs.general_configuration[gauge_cfg_pkg::GC_ALERT_EN_BIT]
                           & (|state_q.flags);
        // empty detection with hysteresis; recovery counts are four times coarser
        if (!state_q.empty) begin
            state_d.empty = cell_voltage_in <=
                {1'b0, state_q.shadow.empty_thresholds[15:gauge_cfg_pkg::ET_TARGET_LSB]};
        end else if (cell_voltage_in > {1'b0, state_q.shadow.empty_thresholds[6:0], 2'b00}) begin
            state_d.empty = 1'b0;
        end
        // the algorithm sees new settings at its next task boundary
        if (task_tick_in) begin
            state_d.shadow = state_q.regs;
        end
    end

    // =====================================================================
    // state register
    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            state_q <= '0;
            state_q.scl_s <= 3'h7;
            state_q.sda_s <= 3'h7;
            state_q.scl_f <= 1'b1;
            state_q.sda_f <= 1'b1;
            state_q.scl_p <= 1'b1;
            state_q.sda_p <= 1'b1;
            state_q.fsm <= gauge_cfg_pkg::LINK_IDLE;
            state_q.regs <= '{gauge_cfg_pkg::NOMINAL_CAPACITY_RST, gauge_cfg_pkg::GENERAL_CONFIGURATION_RST,
                              gauge_cfg_pkg::CHARGE_END_CURRENT_RST, gauge_cfg_pkg::EMPTY_THRESHOLDS_RST,
                              gauge_cfg_pkg::SECONDARY_CONFIGURATION_RST,
                              gauge_cfg_pkg::MODEL_OPTIONS_RST};
            state_q.shadow <= '{gauge_cfg_pkg::NOMINAL_CAPACITY_RST, gauge_cfg_pkg::GENERAL_CONFIGURATION_RST,
                                gauge_cfg_pkg::CHARGE_END_CURRENT_RST, gauge_cfg_pkg::EMPTY_THRESHOLDS_RST,
                                gauge_cfg_pkg::SECONDARY_CONFIGURATION_RST, gauge_cfg_pkg::MODEL_OPTIONS_RST};
        end else begin
            state_q <= state_d;
        end
    end

    // open-drain pins only ever pull low
    assign sda_out = 1'b0;
    assign alert_out = 1'b0;
    assign sda_oe_out = state_q.sda_oe;
    assign alert_oe_out = state_q.alert_oe;
    assign config_out = state_q.shadow;
    assign alert_flags_out = state_q.flags;
    assign empty_out = state_q.empty;

    // =====================================================================
    // assertions
    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (rst_in);
    AST_NOMINAL_RESET: assert property ($past(rst_in) |-> state_q.regs.nominal_capacity == 16'h0BB8)
        else $error("nominal capacity reset value wrong");
    AST_EMPTY_RESET: assert property ($past(rst_in) |-> state_q.regs.empty_thresholds == 16'hA561)
        else $error("empty thresholds reset value wrong");
    AST_CONFIG_RESET: assert property ($past(rst_in) |-> state_q.regs.general_configuration == 16'h2210
        && state_q.regs.secondary_configuration == 16'h3658)
        else $error("configuration reset values wrong");
    AST_CHARGE_END_RESET: assert property ($past(rst_in) |-> state_q.regs.charge_end_current == 16'h0640)
        else $error("charge end current reset value wrong");
    AST_RELOAD_CLEAR: assert property (reload_done_in && !commit |=> !state_q.regs.model_options[15])
        else $error("reload bit not cleared on completion");
    AST_TASK_APPLY: assert property (task_tick_in |=> config_out == $past(state_q.regs))
        else $error("settings not applied at task boundary");
    AST_STICKY_HOLD: assert property (##1 ((($past(state_q.flags & sticky_vec & ~clr_vec))
        & ~state_q.flags) == 4'h0))
        else $error("sticky alert dropped without a clear");
    AST_ALERT_PIN: assert property (alert_oe_out == $past(state_q.regs.general_configuration[2]
        && |state_q.flags))
        else $error("alert pin does not follow enable and flags");
    AST_EMPTY_HOLD: assert property (empty_out && cell_voltage_in <= {1'b0, config_out.empty_thresholds[6:0], 2'b00}
        |=> empty_out)
        else $error("empty released below recovery voltage");
    AST_WORD_WRITE: assert property ($changed(state_q.regs.nominal_capacity) |-> $past(commit))
        else $error("register changed without a full word write");
    AST_BOOT_STRAP: assert property ($past(rst_in) |=> state_q.regs.model_options[3:2]
        == $past({boot_multi_cell_in, boot_high_side_in}))
        else $error("boot detection not captured");
    AST_MODEL_SELECT: assert property (state_q.regs.model_options[7:4] inside {4'h0, 4'h2, 4'h6})
        else $error("unsupported model selection stored");

    COV_WRITE: cover property (commit);
    COV_READ: cover property (state_q.fsm == gauge_cfg_pkg::LINK_RD_DATA
        ##1 state_q.fsm == gauge_cfg_pkg::LINK_RD_ACK);
    COV_ALERT: cover property (alert_oe_out);
    COV_EMPTY: cover property (empty_out ##1 !empty_out);

endmodule

`default_nettype wire

/* File: test_gauge_config_registers.sv */
// self-checking bench for the gauge configuration register bank
`default_nettype none

module test_gauge_config_registers;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [6:0] DEV = 7'h2A; // arbitrary bus address, matches the design default
    logic clk = 1'b0, rst = 1'b1, scl = 1'b1, sda_m = 1'b1, tick = 1'b0, rdone = 1'b0;
    logic [3:0] thr = 4'h0;
    logic [9:0] volt = 10'h3FF;
    logic sda_oe, alert_oe, empty, sda_drv, alert_drv;
    logic [3:0] flags;
    gauge_cfg_pkg::reg_bank_t cfg;
    int num_errors = 0, n_tests = 0;
    int ev[4] = '{331, 330, 388, 389};
    logic [3:0] exv = 4'h6;
    // open-drain wire: pulled up unless either side pulls it low
    wire sda_w = sda_m & (~sda_oe | sda_drv);

    gauge_config_registers i_dut (.sys_clk_in(clk), .rst_in(rst), .scl_in(scl), .sda_in(sda_w),
        .sda_out(sda_drv), .sda_oe_out(sda_oe), .alert_out(alert_drv), .alert_oe_out(alert_oe), .task_tick_in(tick),
        .reload_done_in(rdone), .boot_high_side_in(1'b1), .boot_multi_cell_in(1'b0),
        .threshold_exceeded_in(thr), .cell_voltage_in(volt), .config_out(cfg), .alert_flags_out(flags),
        .empty_out(empty));

    initial begin
        forever #20 clk = ~clk;
    end

    // =====================================================================
    // bus helpers
    task automatic wt(input int n);
        repeat (n) @(negedge clk);
    endtask
    task automatic chk(input string n, input logic [95:0] e, input logic [95:0] s);
        n_tests++;
        if (s !== e) begin
            $display("CHECK FAILED %s expected %h seen %h", n, e, s);
            num_errors++;
        end
    endtask
    // data moves only well after the clock fall, so the filtered lines never see a false start
    task automatic bit_io(input logic b, output logic r);
        wt(4);
        sda_m = b;
        wt(8);
        scl = 1'b1;
        wt(6);
        r = sda_w;
        wt(6);
        scl = 1'b0;
    endtask
    // st high gives a (repeated) start, low gives a stop
    task automatic cond(input logic st);
        wt(4);
        sda_m = st;
        wt(8);
        scl = 1'b1;
        wt(12);
        sda_m = ~st;
        wt(12);
        if (st) scl = 1'b0;
    endtask
    task automatic xb(input logic [7:0] d, input logic m, input logic ck, output logic [7:0] q);
        logic a;
        for (int i = 7; i >= 0; i--) bit_io(d[i], q[i]);
        bit_io(m, a);
        if (ck) chk("ack", 96'h0, {95'h0, a});
    endtask
    task automatic wr(input logic [7:0] ad, input logic [15:0] w);
        logic [7:0] q;
        cond(1'b1);
        xb({DEV, 1'b0}, 1'b1, 1'b1, q);
        xb(ad, 1'b1, 1'b1, q);
        xb(w[7:0], 1'b1, 1'b1, q);
        xb(w[15:8], 1'b1, 1'b1, q);
        cond(1'b0);
    endtask
    task automatic rc(input string n, input logic [7:0] ad, input logic [15:0] e);
        logic [7:0] q;
        logic [15:0] r;
        cond(1'b1);
        xb({DEV, 1'b0}, 1'b1, 1'b1, q);
        xb(ad, 1'b1, 1'b1, q);
        cond(1'b1);
        xb({DEV, 1'b1}, 1'b1, 1'b1, q);
        xb(8'hFF, 1'b0, 1'b0, r[7:0]);
        xb(8'hFF, 1'b1, 1'b0, r[15:8]);
        cond(1'b0);
        chk(n, {80'h0, e}, {80'h0, r});
    endtask
    task automatic report_and_stop;
        $display("tests %0d errors %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // =====================================================================
    // watchdog: a hang counts as a mismatch
    initial begin
        repeat (100000) @(posedge clk);
        num_errors++;
        report_and_stop();
    end

    // =====================================================================
    // main sequence
    initial begin
        wt(4);
        rst = 1'b0;
        wt(8);
        chk("shadow", {16'h0BB8, 16'h2210, 16'h0640, 16'hA561, 16'h3658, 16'h0000}, cfg);
        rc("nominal_capacity", 8'h18, 16'h0BB8);
        rc("general_configuration", 8'h1D, 16'h2210);
        rc("secondary_configuration", 8'hBB, 16'h3658);
        rc("charge_end_current", 8'h1E, 16'h0640);
        rc("empty_thresholds", 8'h3A, 16'hA561);
        rc("model_options", 8'hDB, 16'h0004);
        rc("unmapped", 8'h55, 16'h0000);
        wr(8'h18, 16'h1234);
        rc("nominal_capacity", 8'h18, 16'h1234);
        wr(8'h1E, 16'h0320);
        rc("charge_end_current", 8'h1E, 16'h0320);
        // an unknown model code must not stick; reserved positions are written zero
        wr(8'hDB, 16'hA4F4);
        rc("model_options", 8'hDB, 16'hA404);
        for (int i = 0; i < 3; i++) begin
            wr(8'hDB, 16'h2004 | (16'(i == 0 ? 0 : (i == 1 ? 2 : 6)) << 4));
            rc("model_select", 8'hDB, 16'h2004 | (16'(i == 0 ? 0 : (i == 1 ? 2 : 6)) << 4));
        end
        wr(8'hDB, 16'h8004);
        rc("reload_pending", 8'hDB, 16'h8004);
        rdone = 1'b1;
        wt(1);
        rdone = 1'b0;
        rc("reload_done", 8'hDB, 16'h0004);
        // live word must wait for the task tick before reaching the shadow
        wr(8'h1D, 16'h2214);
        chk("gc_before_tick", {80'h0, 16'h2210}, {80'h0, cfg.general_configuration});
        tick = 1'b1;
        wt(1);
        tick = 1'b0;
        wt(2);
        chk("gc_after_tick", {80'h0, 16'h2214}, {80'h0, cfg.general_configuration});
        thr = 4'hF;
        wt(3);
        chk("flags", 96'hF, {92'h0, flags});
        chk("alert_pin", 96'h2, {94'h0, alert_oe, alert_drv});
        thr = 4'h0;
        wt(3);
        chk("flags_sticky", 96'h4, {92'h0, flags});
        rc("alert_flags", 8'hF0, 16'h0004);
        wr(8'hF0, 16'h0000);
        chk("flags_cleared", 96'h0, {92'h0, flags});
        wr(8'h1D, 16'h2210);
        tick = 1'b1;
        wt(1);
        tick = 1'b0;
        thr = 4'h1;
        wt(3);
        chk("flags_gated", 96'h1, {92'h0, flags});
        chk("alert_off", 96'h0, {94'h0, alert_oe, alert_drv});
        thr = 4'h0;
        wt(3);
        chk("flags_auto", 96'h0, {92'h0, flags});
        // empty at 330 counts, re-armed only above 4 * 97 counts
        foreach (ev[i]) begin
            volt = 10'(ev[i]);
            wt(3);
            chk("empty", {95'h0, exv[i]}, {95'h0, empty});
        end
        report_and_stop();
    end
endmodule

`default_nettype wire
